// file: rtl/amcr_regs.sv
// Mode control register bank of a dual 16-bit converter, with output formatting.
// Assumes serial pins from outside; sys_clk samples them and finds serial clock edges.
`timescale 1ns/100ps
module amcr_regs
  import amcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  input wire logic [15:0] ch1_raw,
  input wire logic [15:0] ch2_raw,
  output logic [15:0] ch1_data,
  output logic [15:0] ch2_data,
  output logic duty_stabilizer_disable,
  output logic ch1_power_down,
  output logic ch2_power_down,
  output logic sleep_active,
  output logic [5:0] driver_current,
  output logic internal_term_enable,
  output logic output_disable,
  output logic [1:0] lane_count_select,
  output logic lane_code_invalid
);

  // Sign flip for two's complement, then optional randomize
  function automatic logic [15:0] amcr_format(input logic [15:0] raw, input logic signed_sel,
                                              input logic scramble);
    logic [15:0] v;
    v = signed_sel ? {~raw[15], raw[14:0]} : raw;
    if (scramble) begin
      v = {v[15:1] ^ {15{v[0]}}, v[0]};
    end
    return v;
  endfunction : amcr_format

  // Two-flop synchronisers for the serial pins
  logic [1:0] cs_sync_q, sck_sync_q, sdi_sync_q;
  logic sck_prev_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cs_sync_q <= 2'b11;
      sck_sync_q <= 2'b00;
      sdi_sync_q <= 2'b00;
      sck_prev_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], spi_cs_n};
      sck_sync_q <= {sck_sync_q[0], spi_sck};
      sdi_sync_q <= {sdi_sync_q[0], spi_sdi};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  logic cs_act, sck_rise, sck_fall;
  assign cs_act = !cs_sync_q[1];
  assign sck_rise = sck_sync_q[1] && !sck_prev_q;
  assign sck_fall = !sck_sync_q[1] && sck_prev_q;

  // Serial word capture: first 16 rising edges count, later ones are ignored
  amcr_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0] rd_shift_q;
  logic [7:0] fmt_q, mode_q, tph_q, tpl_q;
  logic [7:0] rd_val;
  logic [6:0] addr_now;
  assign addr_now = {shift_q[5:0], sdi_sync_q[1]};

  // Read data mux; unmapped addresses and the write-only reset register read zero
  always_comb begin
    case (addr_now)
      AMCR_ADDR_FMT_PWR: rd_val = fmt_q;
      AMCR_ADDR_OUT_MODE: rd_val = mode_q;
      AMCR_ADDR_TP_HIGH: rd_val = tph_q;
      AMCR_ADDR_TP_LOW: rd_val = tpl_q;
      default: rd_val = AMCR_REG_RESET_VAL;
    endcase
  end

  logic word_done, is_read, do_write, soft_reset;
  assign word_done = (state_q == AMCR_DONE) && !cs_act;
  assign is_read = shift_q[15];
  assign do_write = word_done && !is_read;
  assign soft_reset = do_write && (shift_q[14:8] == AMCR_ADDR_RESET) && shift_q[AMCR_RST_BIT];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= AMCR_IDLE;
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else begin
      case (state_q)
        AMCR_IDLE: begin
          bit_cnt_q <= 5'h00;
          if (cs_act) begin
            state_q <= AMCR_SHIFT;
          end
        end
        AMCR_SHIFT: begin
          if (!cs_act) begin
            state_q <= AMCR_IDLE; // Short word is dropped
          end else if (sck_rise) begin
            shift_q <= {shift_q[14:0], sdi_sync_q[1]};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == AMCR_WORD_BITS - 5'h01) begin
              state_q <= AMCR_DONE;
            end
          end
        end
        AMCR_DONE: begin
          if (!cs_act) begin
            state_q <= AMCR_IDLE; // Word acts when chip select rises
          end
        end
        default: state_q <= AMCR_IDLE;
      endcase
    end
  end

  // Readback: open-drain output pulls low for zero bits after the address
  // D7 stands from the 8th rise; the fall after it and each later fall bring the next bit
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_shift_q <= 8'h00;
      spi_sdo_oe <= 1'b0;
      spi_sdo_o <= 1'b0;
    end else if (!cs_act) begin
      spi_sdo_oe <= 1'b0;
    end else if (state_q == AMCR_SHIFT && sck_rise && bit_cnt_q == 5'h07 && shift_q[6]) begin
      rd_shift_q <= rd_val;
      spi_sdo_oe <= !rd_val[7];
    end else if (sck_fall && bit_cnt_q >= 5'h08 && bit_cnt_q < AMCR_WORD_BITS) begin
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      spi_sdo_oe <= !rd_shift_q[6];
    end else if (state_q == AMCR_DONE) begin
      spi_sdo_oe <= 1'b0;
    end
  end

  // Register writes; software reset clears every register
  always_ff @(posedge sys_clk) begin
    if (!reset_n || soft_reset) begin
      fmt_q <= AMCR_REG_RESET_VAL;
      mode_q <= AMCR_REG_RESET_VAL;
      tph_q <= AMCR_REG_RESET_VAL;
      tpl_q <= AMCR_REG_RESET_VAL;
    end else if (do_write) begin
      case (shift_q[14:8])
        AMCR_ADDR_FMT_PWR: fmt_q <= shift_q[7:0];
        AMCR_ADDR_OUT_MODE: mode_q <= shift_q[7:0];
        AMCR_ADDR_TP_HIGH: tph_q <= shift_q[7:0];
        AMCR_ADDR_TP_LOW: tpl_q <= shift_q[7:0];
        default: ;
      endcase
    end
  end

  // Output data path; the pattern bypasses format and randomizer
  logic [15:0] pattern;
  assign pattern = {tph_q, tpl_q};
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ch1_data <= 16'h0000;
      ch2_data <= 16'h0000;
    end else if (mode_q[AMCR_OM_TEST]) begin
      ch1_data <= pattern;
      ch2_data <= pattern;
    end else begin
      ch1_data <= amcr_format(ch1_raw, fmt_q[AMCR_FP_SIGNED], fmt_q[AMCR_FP_SCRAMBLE]);
      ch2_data <= amcr_format(ch2_raw, fmt_q[AMCR_FP_SIGNED], fmt_q[AMCR_FP_SCRAMBLE]);
    end
  end

  // Power state and driver controls, registered for clean outputs
  logic [5:0] cur_base;
  assign cur_base = AMCR_CUR_TABLE[mode_q[AMCR_OM_CUR_HI:AMCR_OM_CUR_LO]];
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      duty_stabilizer_disable <= 1'b0;
      sleep_active <= 1'b0;
      ch1_power_down <= 1'b0;
      ch2_power_down <= 1'b0;
      driver_current <= 6'h00;
      internal_term_enable <= 1'b0;
      output_disable <= 1'b0;
      lane_count_select <= 2'b00;
      lane_code_invalid <= 1'b0;
    end else begin
      duty_stabilizer_disable <= fmt_q[AMCR_FP_DCS_OFF];
      // Soft reset momentarily sleeps the converter as well
      sleep_active <= fmt_q[AMCR_FP_SLEEP] || soft_reset;
      ch1_power_down <= fmt_q[AMCR_FP_SLEEP] || fmt_q[AMCR_FP_NAP1] || soft_reset;
      ch2_power_down <= fmt_q[AMCR_FP_SLEEP] || fmt_q[AMCR_FP_NAP2] || soft_reset;
      // Disabled outputs draw no current; termination doubles it
      if (mode_q[AMCR_OM_OFF]) begin
        driver_current <= 6'h00;
      end else if (mode_q[AMCR_OM_TERM]) begin
        driver_current <= {cur_base[4:0], 1'b0};
      end else begin
        driver_current <= cur_base;
      end
      internal_term_enable <= mode_q[AMCR_OM_TERM];
      output_disable <= mode_q[AMCR_OM_OFF];
      lane_count_select <= mode_q[AMCR_OM_LANE_HI:AMCR_OM_LANE_LO];
      lane_code_invalid <= mode_q[AMCR_OM_LANE_HI:AMCR_OM_LANE_LO] == AMCR_LANE_BAD;
    end
  end

endmodule : amcr_regs

// file: include/amcr_pkg.sv
// Package for the converter mode control register bank.
// Assumes one 50 MHz system clock; serial pins are sampled, not used as clocks.
package amcr_pkg;
  // Register addresses on the serial port (7-bit address field)
  localparam logic [6:0] AMCR_ADDR_RESET = 7'h00;
  localparam logic [6:0] AMCR_ADDR_FMT_PWR = 7'h01;
  localparam logic [6:0] AMCR_ADDR_OUT_MODE = 7'h02;
  localparam logic [6:0] AMCR_ADDR_TP_HIGH = 7'h03;
  localparam logic [6:0] AMCR_ADDR_TP_LOW = 7'h04;
  // Values after reset, hardware or software
  localparam logic [7:0] AMCR_REG_RESET_VAL = 8'h00;
  // Format and power register fields
  localparam int AMCR_FP_DCS_OFF = 7;
  localparam int AMCR_FP_SCRAMBLE = 6;
  localparam int AMCR_FP_SIGNED = 5;
  localparam int AMCR_FP_SLEEP = 4;
  localparam int AMCR_FP_NAP2 = 3;
  localparam int AMCR_FP_NAP1 = 0;
  // Output mode register fields
  localparam int AMCR_OM_CUR_HI = 7;
  localparam int AMCR_OM_CUR_LO = 5;
  localparam int AMCR_OM_TERM = 4;
  localparam int AMCR_OM_OFF = 3;
  localparam int AMCR_OM_TEST = 2;
  localparam int AMCR_OM_LANE_HI = 1;
  localparam int AMCR_OM_LANE_LO = 0;
  // Software reset bit of the reset register
  localparam int AMCR_RST_BIT = 7;
  // Serial word: one command bit, seven address bits, eight data bits
  localparam logic [4:0] AMCR_WORD_BITS = 5'h10;
  // Driver current codes in units of 0.25 mA
  localparam logic [3:0] AMCR_CODE_NONE = 4'h0;
  localparam logic [5:0] AMCR_CUR_TABLE [8] = '{6'h0e, 6'h10, 6'h12, 6'h00,
                                                6'h0c, 6'h0a, 6'h08, 6'h07};
  // Lane count select encodings
  typedef enum logic [1:0] {
    AMCR_LANE2 = 2'b00,
    AMCR_LANE4 = 2'b01,
    AMCR_LANE1 = 2'b10,
    AMCR_LANE_BAD = 2'b11
  } amcr_lane_t;
  // Serial port states
  typedef enum logic [1:0] {
    AMCR_IDLE = 2'b00,
    AMCR_SHIFT = 2'b01,
    AMCR_DONE = 2'b10
  } amcr_state_t;
endpackage : amcr_pkg

// file: testbench/amcr_regs_props.sv
// Checker for the decoded outputs of the register bank.
// Assumes it is bound to amcr_regs and sees only its ports.
`timescale 1ns/100ps
module amcr_regs_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic duty_stabilizer_disable,
  input wire logic ch1_power_down,
  input wire logic ch2_power_down,
  input wire logic sleep_active,
  input wire logic [5:0] driver_current,
  input wire logic internal_term_enable,
  input wire logic output_disable,
  input wire logic [1:0] lane_count_select,
  input wire logic lane_code_invalid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Decoded outputs must agree with each other in every cycle
  a_sleep_both_down: assert property (sleep_active |-> ch1_power_down && ch2_power_down)
    else $error("sleep without both channels down");
  a_off_no_current: assert property (output_disable |-> driver_current == 6'h00)
    else $error("current while outputs off");
  a_lane_bad_flag: assert property (lane_code_invalid == (lane_count_select == 2'b11))
    else $error("lane flag wrong");
  a_current_codes: assert property (!output_disable && !internal_term_enable |->
    driver_current inside {6'h0e, 6'h10, 6'h12, 6'h00, 6'h0c, 6'h0a, 6'h08, 6'h07})
    else $error("current code out of table");
  a_term_doubles: assert property (!output_disable && internal_term_enable |->
    driver_current inside {6'h1c, 6'h20, 6'h24, 6'h00, 6'h18, 6'h14, 6'h10, 6'h0e})
    else $error("current not doubled");
  // Settings only move after a frame has closed, never mid-frame
  a_dcs_after_frame: assert property (!$stable(duty_stabilizer_disable) |->
    spi_cs_n && $past(spi_cs_n, 3))
    else $error("stabilizer moved mid-frame");
  a_nap_after_frame: assert property (!$stable({ch1_power_down, ch2_power_down}) |->
    spi_cs_n && $past(spi_cs_n, 3))
    else $error("nap moved mid-frame");
  a_term_after_frame: assert property ($rose(internal_term_enable) |-> $past(spi_cs_n, 3))
    else $error("termination moved mid-frame");
  c_sleep: cover property (sleep_active);
  c_lane_bad: cover property (lane_code_invalid);
  c_term_on: cover property (internal_term_enable && driver_current != 6'h00);
endmodule : amcr_regs_props
bind amcr_regs amcr_regs_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .spi_cs_n(spi_cs_n), .duty_stabilizer_disable(duty_stabilizer_disable),
  .ch1_power_down(ch1_power_down), .ch2_power_down(ch2_power_down),
  .sleep_active(sleep_active), .driver_current(driver_current),
  .internal_term_enable(internal_term_enable), .output_disable(output_disable),
  .lane_count_select(lane_count_select), .lane_code_invalid(lane_code_invalid));

// file: testbench/amcr_host.sv
// Serial host model: 16-bit frames, command bit first, MSB first.
// Assumes sys_clk at 50 MHz; link clock 160 ns, parked low outside frames.
`timescale 1ns/100ps
module amcr_host (
  input wire logic sys_clk,
  input wire logic sdo,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  // Deselected and quiet until the first frame
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // High phase is long so the synchronised read bit has settled
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge sys_clk) cs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      sdi = (i > 7 && w[15]) ? ~sdi : w[15 - i]; // Junk on SDI during read-back
      repeat (3) @(negedge sys_clk);
      sck = 1'b1;
      repeat (5) @(negedge sys_clk);
      if (i >= 7 && i < 15) rd[14 - i] = sdo;
      sck = 1'b0;
    end
    sdi = ~sdi; // Stale data is never left on the line
    repeat (3) @(negedge sys_clk);
    cs_n = 1'b1;
    repeat (12) @(negedge sys_clk);
  endtask : xfer
endmodule : amcr_host

// file: testbench/amcr_regs_tb.sv
// Self-checking bench: host model programs the bank, bench checks outputs.
// Assumes checker and host model are compiled ahead of this file.
`timescale 1ns/100ps
module amcr_regs_tb import amcr_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, sck, sdi, sdo_o, sdo_oe, ddis, p1, p2, slp, term, off, lbad;
  logic [15:0] r1 = 16'h0000, r2 = 16'h0000, d1, d2, tp;
  logic [5:0] cur;
  logic [1:0] lane;
  logic [7:0] rd, fp, om;
  logic [7:0] cn [4] = '{8'h00, 8'h09, 8'h19, 8'hff};
  logic [5:0] ct [8] = '{6'h0e, 6'h10, 6'h12, 6'h00, 6'h0c, 6'h0a, 6'h08, 6'h07};
  int failures = 0, samples_checked = 0;
  // Clock, and the open-drain line with its pull-up
  always #10 sys_clk = ~sys_clk;
  wire sdo = sdo_oe ? sdo_o : 1'b1;
  amcr_host u_host (.sys_clk(sys_clk), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  amcr_regs u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .spi_cs_n(cs_n), .spi_sck(sck),
    .spi_sdi(sdi), .spi_sdo_o(sdo_o), .spi_sdo_oe(sdo_oe), .ch1_raw(r1), .ch2_raw(r2),
    .ch1_data(d1), .ch2_data(d2), .duty_stabilizer_disable(ddis), .ch1_power_down(p1),
    .ch2_power_down(p2), .sleep_active(slp), .driver_current(cur),
    .internal_term_enable(term), .output_disable(off), .lane_count_select(lane),
    .lane_code_invalid(lbad));
  // Expected output word: sign flip, then scramble above the LSB
  function automatic logic [15:0] fmt(input logic [15:0] r, input logic [7:0] f);
    logic [15:0] x;
    x = f[5] ? {~r[15], r[14:0]} : r;
    return f[6] ? x ^ {{15{x[0]}}, 1'b0} : x;
  endfunction : fmt
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({1'b0, a, d}, 16, rd);
  endtask : wr
  task automatic rdr(input logic [6:0] a, input logic [7:0] e);
    u_host.xfer({1'b1, a, 8'h00}, 16, rd);
    chk("readback", e, rd);
  endtask : rdr
  // Random raw words; t selects the pattern as the expectation
  task automatic dchk(input logic [7:0] f, input logic t);
    repeat (3) begin
      r1 = 16'($urandom);
      r2 = 16'($urandom);
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk("ch1", t ? tp : fmt(r1, f), d1);
      chk("ch2", t ? tp : fmt(r2, f), d2);
    end
  endtask : dchk
  task automatic stop_test;
    $display("Counts: %0d checked, %0d mismatched", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // Watchdog against a hung run
  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h7412ae31));
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int a = 1; a < 6; a++) rdr(7'(a), 8'h00);
    $display("Test reset_values done");
    for (int i = 0; i < 10; i++) begin
      fp = (i < 4) ? cn[i] : 8'($urandom);
      wr(AMCR_ADDR_FMT_PWR, fp);
      chk("dcs", 16'(fp[7]), 16'(ddis));
      chk("pd", {fp[4] | fp[3], fp[4] | fp[0], fp[4]}, {p2, p1, slp});
      rdr(AMCR_ADDR_FMT_PWR, fp);
      dchk(fp, 1'b0);
    end
    $display("Test format_power done");
    for (int i = 0; i < 12; i++) begin
      om = {3'(i), 2'($urandom), 1'b0, 2'(i)};
      wr(AMCR_ADDR_OUT_MODE, om);
      chk("cur", om[3] ? 16'h0000 : 16'(ct[om[7:5]]) << om[4], cur);
      chk("om", {om[4:3], om[1:0], om[1:0] == 2'b11}, {term, off, lane, lbad});
      rdr(AMCR_ADDR_OUT_MODE, om);
    end
    $display("Test output_mode done");
    for (int i = 0; i < 3; i++) begin
      tp = (i == 0) ? 16'h8001 : 16'($urandom);
      wr(AMCR_ADDR_TP_HIGH, tp[15:8]);
      wr(AMCR_ADDR_TP_LOW, tp[7:0]);
      wr(AMCR_ADDR_FMT_PWR, 8'h60);
      wr(AMCR_ADDR_OUT_MODE, 8'h04);
      dchk(8'h60, 1'b1);
      wr(AMCR_ADDR_OUT_MODE, 8'h00);
      dchk(8'h60, 1'b0);
    end
    $display("Test pattern done");
    wr(AMCR_ADDR_RESET, 8'h80);
    for (int a = 1; a < 5; a++) rdr(7'(a), 8'h00);
    $display("Test soft_reset done");
    stop_test();
  end
endmodule : amcr_regs_tb
